/* File: include/bcc_pkg.sv */
// Purpose: Shared constants and types for the block check character calculator
// Assumes: APB register access, 32-bit data, one clock
// Notes:   Register layout and encodings are local choices
// Functional notes
// - Three check formulas for transmit and receive: sum, LRC, CRC-16.
// - Sum mode adds every byte from the range start to the last range byte.
// - Sum mode inverts the total and adds one.
// - Sum result is stored raw or as ASCII, in the configured digit count.
// - ASCII with two digits sends the low byte as two hex characters.
// - LRC mode decodes each pair of ASCII hex characters into one byte.
// - LRC mode sums decoded bytes, then inverts and adds one.
// - LRC mode sends only the low byte as two hex characters.
// - CRC-16 uses polynomial x16+x15+x2+1, least significant bit first.
// - CRC starts from all ones, XORed with the first byte in the low half.
// - Each byte shifts right eight times, XORing the reflected polynomial on carry.
// - Each following byte is XORed in and shifted eight more times.
// - CRC bytes are sent low byte first, high byte second.
`default_nettype none
package bcc_pkg;

    // Register offsets
    localparam logic [11:0] CTRL_OFF    = 12'h000;
    localparam logic [11:0] STATUS_OFF  = 12'h004;
    localparam logic [11:0] RESULT_OFF  = 12'h008;

    // Control field positions
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_ASCII_BIT = 2;
    localparam int          CTRL_DIG_LSB   = 4;
    localparam int          CTRL_RX_BIT    = 8;
    localparam int          CTRL_EN_BIT    = 9;

    // Status field positions
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_DONE_BIT  = 1;
    localparam int          STAT_MISM_BIT  = 2;

    // Reset values
    localparam logic [1:0]  MODE_RST   = 2'h0;
    localparam logic        ASCII_RST  = 1'b0;
    localparam logic [1:0]  DIG_RST    = 2'h1;
    localparam logic        RX_RST     = 1'b0;
    localparam logic        EN_RST     = 1'b0;

    // CRC constants
    localparam logic [15:0] CRC_SEED   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'ha001;
    localparam int          CRC_SHIFTS = 8;

    typedef enum logic [1:0] {
        BCC_SUM  = 2'h0,
        BCC_LRC  = 2'h1,
        BCC_CRC  = 2'h2,
        BCC_RSVD = 2'h3
    } bcc_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RUN  = 3'h1,
        ST_PREP = 3'h3,
        ST_EMIT = 3'h2,
        ST_CMP  = 3'h6
    } bcc_state_e;

endpackage
`default_nettype wire

/* File: include/bcc_crc_if.sv */
// Purpose: Carries the CRC remainder to and from the byte step logic
// Assumes: Purely combinational step
// Notes:   Input already holds the new data byte XORed in
`timescale 1ns/1ps
`default_nettype none
interface bcc_crc_if;
    logic [15:0] crc_in;
    logic [15:0] crc_out;
    modport calc (output crc_in, input crc_out);
    modport step (input crc_in, output crc_out);
endinterface
`default_nettype wire

/* File: verilog/bcc_crc_step.sv */
// Purpose: Eight reflected CRC-16 shifts for one byte
// Assumes: Caller XORs the data byte into the low half
// Notes:   Combinational
`timescale 1ns/1ps
`default_nettype none
module bcc_crc_step (
    bcc_crc_if.step crc
);
    always_comb
    begin
        logic [15:0] v;
        v = crc.crc_in;
        for (int i = 0; i < bcc_pkg::CRC_SHIFTS; i++)
        begin
            // Shift right, fold polynomial on carry
            if (v[0])
            begin
                v = (v >> 1) ^ bcc_pkg::CRC_POLY;
            end
            else
            begin
                v = v >> 1;
            end
        end
        crc.crc_out = v;
    end
endmodule
`default_nettype wire

/* File: verilog/bcc_calc.sv */
// Purpose: Block check character calculator with APB control
// Assumes: Framer feeds one byte per cycle with first and last markers
// Notes:   Transmit emits check bytes; receive compares them
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bcc_calc (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_first,
    input  wire logic        in_last,
    output logic             in_ready,
    output logic             out_valid,
    output logic      [7:0]  out_data,
    output logic             out_last,
    input  wire logic        out_ready,
    output logic             frame_done,
    output logic             check_mismatch
);

    typedef struct packed {
        bcc_pkg::bcc_state_e st;
        logic [1:0]          mode;
        logic                ascii;
        logic [1:0]          dig;
        logic                rx;
        logic                en;
        logic [15:0]         acc;
        logic [15:0]         crc;
        logic [15:0]         res;
        logic [3:0]          nib;
        logic                half;
        logic [2:0]          idx;
        logic [7:0]          odat;
        logic                done;
        logic                mism;
        logic                pulse;
        logic [31:0]         rdata;
    } bcc_state_s;

    bcc_state_s state_ff;
    bcc_state_s nxt_state;

    bcc_crc_if crc_if ();

    bcc_crc_step u_step (
        .crc (crc_if.step)
    );

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        if (n < 4'ha)
        begin
            hex_char = 8'h30 + {4'h0, n};
        end
        else
        begin
            hex_char = 8'h37 + {4'h0, n};
        end
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        if (c >= 8'h61)
        begin
            hex_val = 4'(c - 8'h57);
        end
        else if (c >= 8'h41)
        begin
            hex_val = 4'(c - 8'h37);
        end
        else
        begin
            hex_val = 4'(c - 8'h30);
        end
    endfunction

    // Number of check bytes for the current setup
    function automatic logic [2:0] chk_count(input logic [1:0] mode,
                                             input logic       ascii,
                                             input logic [1:0] dig);
        if (mode == bcc_pkg::BCC_LRC || mode == bcc_pkg::BCC_CRC)
        begin
            chk_count = 3'h2;
        end
        else if (ascii)
        begin
            chk_count = {1'b0, dig} + 3'h1;
        end
        else
        begin
            chk_count = (dig != 2'h0) ? 3'h2 : 3'h1;
        end
    endfunction

    // Check byte at position idx, first sent first
    function automatic logic [7:0] chk_byte(input logic [1:0]  mode,
                                            input logic        ascii,
                                            input logic [1:0]  dig,
                                            input logic [15:0] res,
                                            input logic [15:0] crc,
                                            input logic [2:0]  idx);
        logic [1:0] pos;
        pos = dig - idx[1:0];
        if (mode == bcc_pkg::BCC_CRC)
        begin
            chk_byte = (idx == 3'h0) ? crc[7:0] : crc[15:8];
        end
        else if (mode == bcc_pkg::BCC_LRC)
        begin
            chk_byte = hex_char((idx == 3'h0) ? res[7:4] : res[3:0]);
        end
        else if (ascii)
        begin
            chk_byte = hex_char(res[{pos, 2'b00} +: 4]);
        end
        else if ((dig != 2'h0) && (idx == 3'h0))
        begin
            chk_byte = res[15:8];
        end
        else
        begin
            chk_byte = res[7:0];
        end
    endfunction

    logic        apb_wr;
    logic        apb_setup;
    logic        mapped;
    logic        accept;
    logic [2:0]  cnt;
    logic        last_chk;

    assign apb_wr    = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    assign mapped    = (paddr == bcc_pkg::CTRL_OFF) || (paddr == bcc_pkg::STATUS_OFF)
                       || (paddr == bcc_pkg::RESULT_OFF);
    assign cnt       = chk_count(state_ff.mode, state_ff.ascii, state_ff.dig);
    assign last_chk  = (state_ff.idx == cnt - 3'h1);
    assign accept    = in_valid && in_ready;

    // CRC seed on the first byte, running remainder after
    assign crc_if.crc_in = ((in_first || state_ff.st == bcc_pkg::ST_IDLE) ?
                            bcc_pkg::CRC_SEED : state_ff.crc) ^ {8'h00, in_data};

    always_comb
    begin
        logic [15:0] acc;
        logic        half;
        acc       = 16'h0000;
        half      = 1'b0;
        nxt_state = state_ff;
        nxt_state.pulse = 1'b0;

        // Register writes; status done is write one to clear
        if (apb_wr && paddr == bcc_pkg::CTRL_OFF)
        begin
            nxt_state.mode  = pwdata[bcc_pkg::CTRL_MODE_LSB +: 2];
            nxt_state.ascii = pwdata[bcc_pkg::CTRL_ASCII_BIT];
            nxt_state.dig   = pwdata[bcc_pkg::CTRL_DIG_LSB +: 2];
            nxt_state.rx    = pwdata[bcc_pkg::CTRL_RX_BIT];
            nxt_state.en    = pwdata[bcc_pkg::CTRL_EN_BIT];
        end
        if (apb_wr && paddr == bcc_pkg::STATUS_OFF && pwdata[bcc_pkg::STAT_DONE_BIT])
        begin
            nxt_state.done = 1'b0;
        end

        // Read data captured in the setup cycle
        if (apb_setup)
        begin
            nxt_state.rdata = 32'h0;
            if (paddr == bcc_pkg::CTRL_OFF)
            begin
                nxt_state.rdata[bcc_pkg::CTRL_MODE_LSB +: 2] = state_ff.mode;
                nxt_state.rdata[bcc_pkg::CTRL_ASCII_BIT]     = state_ff.ascii;
                nxt_state.rdata[bcc_pkg::CTRL_DIG_LSB +: 2]  = state_ff.dig;
                nxt_state.rdata[bcc_pkg::CTRL_RX_BIT]        = state_ff.rx;
                nxt_state.rdata[bcc_pkg::CTRL_EN_BIT]        = state_ff.en;
            end
            else if (paddr == bcc_pkg::STATUS_OFF)
            begin
                nxt_state.rdata[bcc_pkg::STAT_BUSY_BIT] = (state_ff.st != bcc_pkg::ST_IDLE);
                nxt_state.rdata[bcc_pkg::STAT_DONE_BIT] = state_ff.done;
                nxt_state.rdata[bcc_pkg::STAT_MISM_BIT] = state_ff.mism;
            end
            else if (paddr == bcc_pkg::RESULT_OFF)
            begin
                nxt_state.rdata[15:0] = (state_ff.mode == bcc_pkg::BCC_CRC) ?
                                        state_ff.crc : state_ff.res;
            end
        end

        unique case (state_ff.st)
            bcc_pkg::ST_IDLE,
            bcc_pkg::ST_RUN:
            begin
                if (accept && (in_first || state_ff.st == bcc_pkg::ST_RUN))
                begin
                    acc  = in_first ? 16'h0000 : state_ff.acc;
                    half = in_first ? 1'b0 : state_ff.half;
                    if (in_first)
                    begin
                        nxt_state.mism = 1'b0;
                    end
                    // Formula selection
                    if (state_ff.mode == bcc_pkg::BCC_LRC)
                    begin
                        // Pair of characters to one byte
                        if (!half)
                        begin
                            nxt_state.nib = hex_val(in_data);
                            half          = 1'b1;
                        end
                        else
                        begin
                            acc  = acc + {8'h00, state_ff.nib, hex_val(in_data)};
                            half = 1'b0;
                        end
                    end
                    else if (state_ff.mode == bcc_pkg::BCC_CRC)
                    begin
                        nxt_state.crc = crc_if.crc_out;
                    end
                    else
                    begin
                        acc = acc + {8'h00, in_data};
                    end
                    nxt_state.acc  = acc;
                    nxt_state.half = half;
                    if (in_last)
                    begin
                        nxt_state.res = ~acc + 16'h0001;
                        nxt_state.st  = bcc_pkg::ST_PREP;
                    end
                    else
                    begin
                        nxt_state.st = bcc_pkg::ST_RUN;
                    end
                end
            end
            bcc_pkg::ST_PREP:
            begin
                nxt_state.idx  = 3'h0;
                nxt_state.odat = chk_byte(state_ff.mode, state_ff.ascii, state_ff.dig,
                                          state_ff.res, state_ff.crc, 3'h0);
                nxt_state.st   = state_ff.rx ? bcc_pkg::ST_CMP : bcc_pkg::ST_EMIT;
            end
            bcc_pkg::ST_EMIT,
            bcc_pkg::ST_CMP:
            begin
                if ((state_ff.st == bcc_pkg::ST_EMIT && out_ready) ||
                    (state_ff.st == bcc_pkg::ST_CMP && in_valid))
                begin
                    if (state_ff.st == bcc_pkg::ST_CMP && in_data != state_ff.odat)
                    begin
                        nxt_state.mism = 1'b1;
                    end
                    if (last_chk)
                    begin
                        nxt_state.st    = bcc_pkg::ST_IDLE;
                        nxt_state.done  = 1'b1;
                        nxt_state.pulse = 1'b1;
                    end
                    else
                    begin
                        nxt_state.idx  = state_ff.idx + 3'h1;
                        nxt_state.odat = chk_byte(state_ff.mode, state_ff.ascii, state_ff.dig,
                                                  state_ff.res, state_ff.crc,
                                                  state_ff.idx + 3'h1);
                    end
                end
            end
            default:
            begin
                nxt_state.st = bcc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff       <= '0;
            state_ff.st    <= bcc_pkg::ST_IDLE;
            state_ff.mode  <= bcc_pkg::MODE_RST;
            state_ff.ascii <= bcc_pkg::ASCII_RST;
            state_ff.dig   <= bcc_pkg::DIG_RST;
            state_ff.rx    <= bcc_pkg::RX_RST;
            state_ff.en    <= bcc_pkg::EN_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign prdata         = state_ff.rdata;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !mapped;
    assign in_ready       = state_ff.en && (state_ff.st == bcc_pkg::ST_IDLE ||
                            state_ff.st == bcc_pkg::ST_RUN || state_ff.st == bcc_pkg::ST_CMP);
    assign out_valid      = (state_ff.st == bcc_pkg::ST_EMIT);
    assign out_data       = state_ff.odat;
    assign out_last       = out_valid && last_chk;
    assign frame_done     = state_ff.pulse;
    assign check_mismatch = state_ff.mism;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sum_negate_a: assert property (
        (state_ff.st == bcc_pkg::ST_PREP && state_ff.mode != bcc_pkg::BCC_CRC)
        |-> (16'(state_ff.res + state_ff.acc) == 16'h0000))
        else $error("check value is not the negated sum");

    crc_seed_a: assert property (
        (accept && in_first)
        |-> (crc_if.crc_in == (16'hffff ^ {8'h00, in_data})))
        else $error("crc seed not all ones xor first byte");

    crc_low_first_a: assert property (
        (state_ff.st == bcc_pkg::ST_PREP && state_ff.mode == bcc_pkg::BCC_CRC && !state_ff.rx)
        |=> (out_valid && out_data == $past(state_ff.crc[7:0])))
        else $error("crc low byte not first");

    crc_high_second_a: assert property (
        (out_valid && out_ready && state_ff.idx == 3'h0 && state_ff.mode == bcc_pkg::BCC_CRC)
        |=> (out_valid && out_last && out_data == $past(state_ff.crc[15:8])))
        else $error("crc high byte not second");

    hex_char_a: assert property (
        (out_valid && (state_ff.ascii || state_ff.mode == bcc_pkg::BCC_LRC)
         && state_ff.mode != bcc_pkg::BCC_CRC)
        |-> ((out_data >= 8'h30 && out_data <= 8'h39) || (out_data >= 8'h41 && out_data <= 8'h46)))
        else $error("check character is not ascii hex");

    lrc_two_chars_a: assert property (
        (out_valid && state_ff.mode == bcc_pkg::BCC_LRC)
        |-> (out_last == (state_ff.idx == 3'h1)))
        else $error("lrc check field is not two characters");

    lrc_pair_hold_a: assert property (
        (accept && state_ff.st == bcc_pkg::ST_RUN && !in_first
         && state_ff.mode == bcc_pkg::BCC_LRC && !state_ff.half)
        |=> (state_ff.half && state_ff.acc == $past(state_ff.acc)))
        else $error("lrc added a lone character");

    mismatch_set_a: assert property (
        (state_ff.st == bcc_pkg::ST_CMP && in_valid && in_data != state_ff.odat)
        |=> check_mismatch [*1] ##0 (state_ff.st != bcc_pkg::ST_RUN))
        else $error("mismatch not flagged");

    done_pulse_a: assert property (
        frame_done |-> (state_ff.done && state_ff.st == bcc_pkg::ST_IDLE) ##1 !frame_done)
        else $error("frame done not a single pulse");

endmodule
`default_nettype wire

/* File: verif/bcc_framer_model.sv */
// Purpose: Framer model feeding ranges and taking check bytes
// Assumes: Caller starts each send just after a rising edge
// Notes:   Data line shows the inverse byte once released
`timescale 1ns/1ps
`default_nettype none
module bcc_framer_model (
    input  wire logic       pclk,
    output logic            in_valid,
    output logic [7:0]      in_data,
    output logic            in_first,
    output logic            in_last,
    input  wire logic       in_ready,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output logic            out_ready,
    input  wire logic       frame_done
);
    logic [7:0] got [8];
    logic       got_last [8];
    int         got_n = 0;
    int         done_n = 0;
    logic       stall = 1'b0;

    initial
    begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_first = 1'b0;
        in_last = 1'b0;
        out_ready = 1'b0;
    end

    // Takes check bytes, stalling on every other cycle if asked
    always @(posedge pclk)
    begin
        out_ready <= stall ? ~out_ready : 1'b1;
        if (out_valid && out_ready && got_n < 8)
        begin
            got[got_n] <= out_data;
            got_last[got_n] <= out_last;
            got_n <= got_n + 1;
        end
        if (frame_done)
            done_n <= done_n + 1;
    end

    task automatic clear();
        got_n = 0;
        done_n = 0;
    endtask

    // Bytes 0..nl-1 form the range, later ones are received check bytes
    task automatic send(input logic [7:0] b [16], input int n, input int nl);
        for (int i = 0; i < n; i++)
        begin
            in_valid <= 1'b1;
            in_data <= b[i];
            in_first <= (i == 0);
            in_last <= (i == nl - 1);
            do @(posedge pclk); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        in_data <= ~b[n-1];
        in_first <= 1'b0;
        in_last <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the check character calculator
// Assumes: Zero wait APB slave, framer model on the stream side
// Notes:   Expected values computed here from the formulas
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid;
    logic [7:0]  in_data;
    logic        in_first;
    logic        in_last;
    logic        in_ready;
    logic        out_valid;
    logic [7:0]  out_data;
    logic        out_last;
    logic        out_ready;
    logic        frame_done;
    logic        check_mismatch;
    logic [7:0]  fr [16];
    logic [7:0]  ex [8];
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;

    bcc_calc i_bcc_calc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data), .in_first(in_first),
        .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready), .frame_done(frame_done),
        .check_mismatch(check_mismatch));
    bcc_framer_model i_bcc_framer_model (.pclk(pclk), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .out_ready(out_ready), .frame_done(frame_done));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors=%0d tests=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        n_tests++;
        if (a !== e)
        begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cw(input logic [1:0] md, input logic a,
                                       input logic [1:0] d, input logic rx);
        return {22'h0, 1'b1, rx, 2'h0, d, 1'b0, a, md};
    endfunction

    function automatic logic [7:0] hx(input logic [3:0] v);
        return (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
    endfunction

    function automatic logic [3:0] uh(input logic [7:0] c);
        return (c < 8'h3a) ? 4'(c - 8'h30) : 4'(c - 8'h37 - ((c > 8'h60) ? 8'h20 : 8'h00));
    endfunction

    function automatic logic [15:0] crc16(input int n);
        logic [15:0] r;
        r = 16'hffff;
        for (int i = 0; i < n; i++)
        begin
            r ^= {8'h00, fr[i]};
            for (int j = 0; j < 8; j++)
                r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
        end
        return r;
    endfunction

    task automatic run_frame(input logic [31:0] c, input int n, input int m, input logic st);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, bcc_pkg::CTRL_OFF, c, rd, err);
        i_bcc_framer_model.stall = st;
        i_bcc_framer_model.clear();
        i_bcc_framer_model.send(fr, n, n);
        for (int k = 0; k < 100 && i_bcc_framer_model.got_n < m; k++)
            @(posedge pclk);
        repeat (3) @(posedge pclk);
        chk(m, i_bcc_framer_model.got_n);
        for (int k = 0; k < m; k++)
            chk(ex[k], i_bcc_framer_model.got[k]);
        chk(1, i_bcc_framer_model.got_last[m-1]);
        chk(1, i_bcc_framer_model.done_n);
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, bcc_pkg::CTRL_OFF, 32'h0, rd, err);
        chk(32'h00000010, rd);
        apb(1'b0, bcc_pkg::STATUS_OFF, 32'h0, rd, err);
        chk(32'h00000000, rd);
        apb(1'b1, 12'h00c, 32'hffffffff, rd, err);
        chk(1, err);
        apb(1'b0, 12'h00c, 32'h0, rd, err);
        chk(1, err);
        chk(32'h0, rd);
    endtask

    task automatic t_sum();
        logic [15:0] s;
        logic [31:0] rd;
        logic        err;
        int          m;
        s = 16'h0;
        for (int i = 0; i < 7; i++)
        begin
            fr[i] = 8'(8'hd7 + 8'h3b * i);
            s += fr[i];
        end
        s = ~s + 16'h1;
        for (int a = 0; a < 2; a++)
            for (int d = 0; d < 4; d++)
            begin
                m = a ? d + 1 : (d == 0 ? 1 : 2);
                for (int k = 0; k < m; k++)
                    ex[k] = a ? hx(4'(s >> (4 * (d - k))))
                            : (m == 1 ? s[7:0] : 8'(s >> (8 - 8 * k)));
                run_frame(cw(2'(3 * a), a, 2'(d), 1'b0),
                          7, m, d[0]);
            end
        apb(1'b0, bcc_pkg::RESULT_OFF, 32'h0, rd, err);
        chk({16'h0, s}, rd);
    endtask

    task automatic t_lrc();
        string      t;
        logic [7:0] l;
        t = "0103a0Ff7E";
        l = 8'h0;
        for (int i = 0; i < 10; i++)
            fr[i] = t[i];
        for (int i = 0; i < 5; i++)
            l += {uh(fr[2*i]), uh(fr[2*i+1])};
        l = ~l + 8'h1;
        ex[0] = hx(l[7:4]);
        ex[1] = hx(l[3:0]);
        run_frame(cw(bcc_pkg::BCC_LRC, 1'b1, 2'h1, 1'b0),
                  10, 2, 1'b1);
    endtask

    task automatic t_crc();
        logic [15:0] r;
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 6; i++)
            fr[i] = 8'(8'h01 + 8'h5c * i);
        r = crc16(6);
        ex[0] = r[7:0];
        ex[1] = r[15:8];
        run_frame(cw(bcc_pkg::BCC_CRC, 1'b0, 2'h1, 1'b0),
                  6, 2, 1'b1);
        apb(1'b0, bcc_pkg::RESULT_OFF, 32'h0, rd, err);
        chk({16'h0, r}, rd);
    endtask

    task automatic t_rx();
        logic [15:0] r;
        logic [31:0] rd;
        logic        err;
        r = crc16(6);
        apb(1'b1, bcc_pkg::CTRL_OFF, cw(bcc_pkg::BCC_CRC, 1'b0, 2'h1, 1'b1), rd, err);
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, bcc_pkg::STATUS_OFF, 32'h2, rd, err);
            fr[6] = r[7:0];
            fr[7] = r[15:8] ^ 8'(p);
            i_bcc_framer_model.clear();
            i_bcc_framer_model.send(fr, 8, 6);
            repeat (4) @(posedge pclk);
            chk(p, check_mismatch);
            chk(1, i_bcc_framer_model.done_n);
            apb(1'b0, bcc_pkg::STATUS_OFF, 32'h0, rd, err);
            chk(p ? 32'h6 : 32'h2, rd);
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sum();
        t_lrc();
        t_crc();
        t_rx();
        summarize();
    end
endmodule
`default_nettype wire
